// [common/sensor_user_config_pkg.sv]
// types shared by the configuration register design files
package sensor_user_config_pkg;

  // serial slave sequencer states, one-hot
  typedef enum logic [8:0] {
    ST_IDLE      = 9'h001,
    ST_ADDR      = 9'h002,
    ST_ADDR_ACK  = 9'h004,
    ST_CMD       = 9'h008,
    ST_CMD_ACK   = 9'h010,
    ST_WDATA     = 9'h020,
    ST_WDATA_ACK = 9'h040,
    ST_RDATA     = 9'h080,
    ST_RACK      = 9'h100
  } slave_state_t;

  // whole state of the register block
  typedef struct packed {
    slave_state_t state;
    logic scl_prev;
    logic sda_prev;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic rnw;
    logic res_high;
    logic res_low;
    logic heater;
    logic supply_low;
    logic sda_oe;
    logic sda_o;
    logic [1:0] conv_res;
  } cfg_state_t;

  // two-stage synchroniser state
  typedef struct packed {
    logic [2:0] stage1;
    logic [2:0] stage2;
  } sync_state_t;

endpackage

// [common/sensor_user_config_regs.svh]
// constants of the user configuration register and its serial command set
`ifndef SENSOR_USER_CONFIG_REGS_SVH
`define SENSOR_USER_CONFIG_REGS_SVH

// serial bus identity and command codes
`define UCFG_SLAVE_ADDR 7'h40
`define UCFG_CMD_WRITE 8'hE6
`define UCFG_CMD_READ 8'hE7

// field positions inside the configuration byte
`define UCFG_RES_HIGH_POS 7
`define UCFG_SUPPLY_LOW_POS 6
`define UCFG_HEATER_POS 2
`define UCFG_RES_LOW_POS 0

// reserved positions read back as ones
`define UCFG_RSVD_MASK 8'h3A
`define UCFG_RESET_VALUE 8'h3A

// byte framing: eight data bits then the acknowledge slot
`define UCFG_BITS_PER_BYTE 4'h8

`endif

// [dv/i2c_host_model.sv]
// serial bus host model: drives the clock line and an open-drain data line
`timescale 1ns/1ns
`include "sensor_user_config_regs.svh"
module i2c_host_model (
  // clock
  input wire logic sys_clk_in,
  // device pulling data low
  input wire logic sda_oe_in,
  // value the device puts on the line while enabled
  input wire logic sda_drive_in,
  // bus lines as the device sees them
  output logic scl_out,
  output logic sda_out
);
  logic sda_rel = 1'b1;
  initial scl_out = 1'b1;
  // pull-up wins unless a party pulls low, so a released line never shows stale data;
  // the device's drive value is used, so a wrong drive level breaks its acknowledge
  assign sda_out = sda_rel & (sda_oe_in ? sda_drive_in : 1'b1);
  // ************************
  // bus phases
  // ************************
  // six cycles a phase keeps each clock phase above the four-cycle minimum
  task automatic half();
    repeat (6) @(negedge sys_clk_in);
  endtask
  task automatic start();
    @(negedge sys_clk_in);
    sda_rel = 1'b1;
    half();
    scl_out = 1'b1;
    half();
    sda_rel = 1'b0;
    half();
    scl_out = 1'b0;
  endtask
  task automatic stop();
    @(negedge sys_clk_in);
    sda_rel = 1'b0;
    half();
    scl_out = 1'b1;
    half();
    sda_rel = 1'b1;
    half();
  endtask
  // eight bits msb first then the acknowledge slot; data moves one cycle after clock fall
  task automatic xfer(input logic [7:0] d, input logic ack_bit, output logic [7:0] r, output logic ack);
    logic [8:0] tx;
    logic [8:0] rx;
    tx = {d, ack_bit};
    for (int i = 8; i >= 0; i--) begin
      @(negedge sys_clk_in);
      sda_rel = tx[i];
      half();
      scl_out = 1'b1;
      half();
      rx[i] = sda_out;
      scl_out = 1'b0;
    end
    r = rx[8:1];
    ack = ~rx[0];
  endtask
  // only the configuration location is ever written
  task automatic wr(input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    xfer({`UCFG_SLAVE_ADDR, 1'b0}, 1'b1, r, a0);
    xfer(`UCFG_CMD_WRITE, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // more set acknowledges the byte and clocks one further byte
  task automatic rd(input logic more, output logic [7:0] d, output logic [7:0] extra, output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, m;
    start();
    xfer({`UCFG_SLAVE_ADDR, 1'b0}, 1'b1, r, a0);
    xfer(`UCFG_CMD_READ, 1'b1, r, a1);
    start();
    xfer({`UCFG_SLAVE_ADDR, 1'b1}, 1'b1, r, a2);
    xfer(8'hFF, ~more, d, m);
    extra = 8'hFF;
    if (more) begin
      xfer(8'hFF, 1'b1, extra, m);
    end
    stop();
    ok = a0 & a1 & a2;
  endtask
  // read first, then write reserved bits back as read
  task automatic rmw(input logic [7:0] d, output logic ok);
    logic [7:0] cur;
    logic [7:0] x;
    rd(1'b0, cur, x, ok);
    wr((d & ~`UCFG_RSVD_MASK) | (cur & `UCFG_RSVD_MASK), ok);
  endtask
endmodule

// [dv/sensor_user_config_register_tb.sv]
// self-checking bench for the user configuration register
`timescale 1ns/1ns
`include "sensor_user_config_regs.svh"
module sensor_user_config_register_tb;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic supply_low_in = 1'b0;
  logic conv_start_in = 1'b0;
  logic scl, sda, sda_drive, sda_oe, heater, flag, ok;
  logic [1:0] conv_res, res_sel;
  logic [7:0] d, img, extra;
  int n_errors = 0;
  int checked = 0;
  sensor_user_config_register u_dut (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl),
    .sda_in(sda), .sda_out(sda_drive), .sda_oe_out(sda_oe), .supply_low_in(supply_low_in),
    .conv_start_in(conv_start_in), .conv_resolution_out(conv_res), .heater_enable_bit_out(heater),
    .resolution_select_out(res_sel), .supply_low_flag_out(flag));
  i2c_host_model u_host (.sys_clk_in(sys_clk_in), .sda_oe_in(sda_oe), .sda_drive_in(sda_drive), .scl_out(scl),
    .sda_out(sda));
  // ************************
  // helpers
  // ************************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // reserved positions always come back as ones
  function automatic logic [7:0] image(input logic [7:0] w, input logic low);
    return {w[7], low, 3'b111, w[2], 1'b1, w[0]};
  endfunction
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  // watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    n_errors++;
    tally_and_finish();
  end
  // ************************
  // tests
  // ************************
  initial begin
    void'($urandom(32'hf118f14e));
    repeat (3) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    check("heater", 8'h00, heater);
    check("resolution", 8'h00, res_sel);
    u_host.rd(1'b0, img, extra, ok);
    check("read ack", 8'h01, ok);
    check("reset image", `UCFG_RESET_VALUE, img);
    $display("test reset done");
    // corners first, then random bytes with reserved bits left as drawn
    for (int i = 0; i < 10; i++) begin
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom());
      supply_low_in = (i > 1) ? 1'($urandom()) : 1'b0;
      u_host.wr(d, ok);
      check("write ack", 8'h01, ok);
      check("heater", {7'h00, d[2]}, heater);
      check("resolution", {6'h00, d[7], d[0]}, res_sel);
      check("supply flag", {7'h00, supply_low_in}, flag);
      u_host.rd(1'b0, img, extra, ok);
      check("image", image(d, supply_low_in), img);
    end
    $display("test random writes done");
    // every resolution code, latched only at a conversion start
    for (int c = 0; c < 4; c++) begin
      u_host.rmw({c[1], 6'h00, c[0]}, ok);
      check("resolution", 8'(c), res_sel);
      @(negedge sys_clk_in);
      conv_start_in = 1'b1;
      @(negedge sys_clk_in);
      conv_start_in = 1'b0;
      check("conv width", 8'(c), conv_res);
    end
    u_host.wr(8'h00, ok);
    check("conv held", 8'h03, conv_res);
    $display("test resolution done");
    // a foreign address must be ignored up to the next start
    u_host.wr(8'h04, ok);
    u_host.start();
    u_host.xfer(8'h84, 1'b1, img, ok);
    check("foreign ack", 8'h00, ok);
    u_host.xfer(`UCFG_CMD_WRITE, 1'b1, img, ok);
    u_host.xfer(8'h00, 1'b1, img, ok);
    u_host.stop();
    check("heater kept", 8'h01, heater);
    $display("test foreign address done");
    // a read with no read command before it returns an all-ones byte
    u_host.start();
    u_host.xfer({`UCFG_SLAVE_ADDR, 1'b1}, 1'b1, img, ok);
    check("read ack", 8'h01, ok);
    u_host.xfer(8'hFF, 1'b1, img, ok);
    check("no command", 8'hFF, img);
    u_host.stop();
    $display("test read without command done");
    // host acknowledges the byte, yet nothing may follow it
    u_host.rd(1'b1, img, extra, ok);
    check("image", image(8'h04, supply_low_in), img);
    check("after byte", 8'hFF, extra);
    $display("test no checksum done");
    // a second reset in mid-run must restore every field
    supply_low_in = 1'b0;
    sys_rst_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge sys_clk_in);
    check("heater", 8'h00, heater);
    check("conv width", 8'h00, conv_res);
    u_host.rd(1'b0, img, extra, ok);
    check("reset image", `UCFG_RESET_VALUE, img);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule

// [rtl/pin_sync.sv]
// two-flop synchroniser for the asynchronous pin inputs
`timescale 1ns/1ns
module pin_sync (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // asynchronous pins and their synchronised copies
  input wire logic [2:0] pins_in,
  output logic [2:0] pins_out
);
  sensor_user_config_pkg::sync_state_t st_q;
  sensor_user_config_pkg::sync_state_t st_d;

  // each pin passes two flops; the first is read only by the second
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_bit
      always_comb begin
        st_d.stage1[gi] = pins_in[gi];
        st_d.stage2[gi] = st_q.stage1[gi];
      end
    end
  endgenerate

  // bus pins idle high and the supply monitor idles low; resetting to those levels
  // avoids a false start and a false low-supply flag just after reset
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_q <= '{stage1: 3'h3, stage2: 3'h3};
    end else begin
      st_q <= st_d;
    end
  end

  assign pins_out = st_q.stage2;
endmodule

// [rtl/sensor_user_config_register.sv]
// user configuration register with its serial bus slave
`timescale 1ns/1ns
`include "sensor_user_config_regs.svh"
module sensor_user_config_register (
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // serial bus pins, data is open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // supply monitor comparator, asynchronous
  input wire logic supply_low_in,
  // measurement engine handshake
  input wire logic conv_start_in,
  output logic [1:0] conv_resolution_out,
  // configuration to the analog side
  output logic heater_enable_bit_out,
  output logic [1:0] resolution_select_out,
  output logic supply_low_flag_out
);
  // ***************************************************
  // pin synchronisation
  // ***************************************************
  logic [2:0] pins_sync;
  logic scl_s;
  logic sda_s;
  logic supply_s;

  pin_sync u_pin_sync (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .pins_in({supply_low_in, sda_in, scl_in}),
    .pins_out(pins_sync)
  );

  assign scl_s = pins_sync[0];
  assign sda_s = pins_sync[1];
  assign supply_s = pins_sync[2];

  // ***************************************************
  // state and bus events
  // ***************************************************
  sensor_user_config_pkg::cfg_state_t st_q;
  sensor_user_config_pkg::cfg_state_t st_d;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic [7:0] cfg_read;
  logic wr_commit;
  logic rd_load;

  // start and stop are data edges while the clock stays high
  assign scl_rise = scl_s && !st_q.scl_prev;
  assign scl_fall = !scl_s && st_q.scl_prev;
  assign bus_start = scl_s && st_q.scl_prev && st_q.sda_prev && !sda_s;
  assign bus_stop = scl_s && st_q.scl_prev && !st_q.sda_prev && sda_s;

  // read image: reserved bits are constant ones, never stored
  assign cfg_read = {st_q.res_high, st_q.supply_low, 3'h7, st_q.heater, 1'h1, st_q.res_low};

  assign wr_commit = (st_q.state == sensor_user_config_pkg::ST_WDATA) && scl_fall
                     && (st_q.bit_cnt == `UCFG_BITS_PER_BYTE);
  assign rd_load = (st_q.state == sensor_user_config_pkg::ST_ADDR_ACK) && scl_fall && st_q.rnw
                   && !bus_start && !bus_stop;

  // ***************************************************
  // next-state logic
  // ***************************************************
  always_comb begin
    st_d = st_q;
    st_d.scl_prev = scl_s;
    st_d.sda_prev = sda_s;
    st_d.sda_o = 1'b0;
    st_d.supply_low = supply_s;
    // the conversion samples the register only at its start
    if (conv_start_in) begin
      st_d.conv_res = {st_q.res_high, st_q.res_low};
    end
    if (bus_start) begin
      // a repeated start keeps the stored command for the read phase
      st_d.state = sensor_user_config_pkg::ST_ADDR;
      st_d.bit_cnt = 4'h0;
      st_d.sda_oe = 1'b0;
    end else if (bus_stop) begin
      st_d.state = sensor_user_config_pkg::ST_IDLE;
      st_d.sda_oe = 1'b0;
    end else if (scl_rise) begin
      unique case (st_q.state)
        sensor_user_config_pkg::ST_ADDR,
        sensor_user_config_pkg::ST_CMD,
        sensor_user_config_pkg::ST_WDATA: begin
          st_d.shift = {st_q.shift[6:0], sda_s};
          st_d.bit_cnt = st_q.bit_cnt + 4'h1;
        end
        sensor_user_config_pkg::ST_RACK: begin
          // one byte only: no checksum, whatever the host answers
          st_d.state = sensor_user_config_pkg::ST_IDLE;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      unique case (st_q.state)
        sensor_user_config_pkg::ST_ADDR: begin
          if (st_q.bit_cnt == `UCFG_BITS_PER_BYTE) begin
            if (st_q.shift[7:1] == `UCFG_SLAVE_ADDR) begin
              st_d.state = sensor_user_config_pkg::ST_ADDR_ACK;
              st_d.rnw = st_q.shift[0];
              st_d.sda_oe = 1'b1;
            end else begin
              st_d.state = sensor_user_config_pkg::ST_IDLE;
            end
          end
        end
        sensor_user_config_pkg::ST_ADDR_ACK: begin
          st_d.bit_cnt = 4'h0;
          if (st_q.rnw) begin
            // only the read command has a defined byte; others float high
            st_d.shift = (st_q.cmd == `UCFG_CMD_READ) ? cfg_read : 8'hFF;
            st_d.sda_oe = (st_q.cmd == `UCFG_CMD_READ) ? !cfg_read[7] : 1'b0;
            st_d.state = sensor_user_config_pkg::ST_RDATA;
          end else begin
            st_d.sda_oe = 1'b0;
            st_d.state = sensor_user_config_pkg::ST_CMD;
          end
        end
        sensor_user_config_pkg::ST_CMD: begin
          if (st_q.bit_cnt == `UCFG_BITS_PER_BYTE) begin
            st_d.cmd = st_q.shift;
            st_d.sda_oe = 1'b1;
            st_d.state = sensor_user_config_pkg::ST_CMD_ACK;
          end
        end
        sensor_user_config_pkg::ST_CMD_ACK: begin
          st_d.sda_oe = 1'b0;
          st_d.bit_cnt = 4'h0;
          // other commands wait for a repeated start or a stop
          st_d.state = (st_q.cmd == `UCFG_CMD_WRITE) ? sensor_user_config_pkg::ST_WDATA
                                                      : sensor_user_config_pkg::ST_IDLE;
        end
        sensor_user_config_pkg::ST_WDATA: begin
          if (st_q.bit_cnt == `UCFG_BITS_PER_BYTE) begin
            // reserved and status positions of the data byte are dropped
            st_d.res_high = st_q.shift[`UCFG_RES_HIGH_POS];
            st_d.heater = st_q.shift[`UCFG_HEATER_POS];
            st_d.res_low = st_q.shift[`UCFG_RES_LOW_POS];
            st_d.sda_oe = 1'b1;
            st_d.state = sensor_user_config_pkg::ST_WDATA_ACK;
          end
        end
        sensor_user_config_pkg::ST_WDATA_ACK: begin
          st_d.sda_oe = 1'b0;
          st_d.state = sensor_user_config_pkg::ST_IDLE;
        end
        sensor_user_config_pkg::ST_RDATA: begin
          st_d.shift = {st_q.shift[6:0], 1'b1};
          st_d.bit_cnt = st_q.bit_cnt + 4'h1;
          if (st_q.bit_cnt == 4'h7) begin
            st_d.sda_oe = 1'b0;
            st_d.state = sensor_user_config_pkg::ST_RACK;
          end else begin
            st_d.sda_oe = !st_q.shift[6];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ***************************************************
  // state register
  // ***************************************************
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      st_q.state <= sensor_user_config_pkg::ST_IDLE;
      st_q.scl_prev <= 1'b1;
      st_q.sda_prev <= 1'b1;
      st_q.bit_cnt <= 4'h0;
      st_q.shift <= 8'hFF;
      st_q.cmd <= 8'h00;
      st_q.rnw <= 1'b0;
      st_q.res_high <= 1'(`UCFG_RESET_VALUE >> `UCFG_RES_HIGH_POS);
      st_q.res_low <= 1'(`UCFG_RESET_VALUE >> `UCFG_RES_LOW_POS);
      st_q.heater <= 1'(`UCFG_RESET_VALUE >> `UCFG_HEATER_POS);
      st_q.supply_low <= 1'b0;
      st_q.sda_oe <= 1'b0;
      st_q.sda_o <= 1'b0;
      st_q.conv_res <= 2'h0;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from the state register; heater drives the element
  assign heater_enable_bit_out = st_q.heater;
  assign resolution_select_out = {st_q.res_high, st_q.res_low};
  assign supply_low_flag_out = st_q.supply_low;
  assign conv_resolution_out = st_q.conv_res;
  assign sda_oe_out = st_q.sda_oe;
  assign sda_out = st_q.sda_o;

  // ***************************************************
  // assertions
  // ***************************************************
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  heater_follows_write_a: assert property (wr_commit |=> heater_enable_bit_out == $past(st_q.shift[2]))
    else $error("heater does not follow written bit");
  layout_read_a: assert property (rd_load && st_q.cmd == `UCFG_CMD_READ |=>
      st_q.shift[7] == st_q.res_high && st_q.shift[2] == st_q.heater && st_q.shift[0] == st_q.res_low)
    else $error("read image layout wrong");
  reserved_ones_a: assert property (rd_load |=> st_q.shift[5:3] == 3'h7 && st_q.shift[1])
    else $error("reserved bits not read as one");
  supply_flag_a: assert property (1'b1 |=> supply_low_flag_out == $past(supply_s))
    else $error("supply flag does not follow monitor");
  conv_sample_a: assert property (conv_start_in |=> conv_resolution_out == $past(resolution_select_out))
    else $error("conversion width not sampled at start");
  conv_hold_a: assert property (!conv_start_in |=> $stable(conv_resolution_out))
    else $error("conversion width changed mid conversion");
  wrong_addr_a: assert property (st_q.state == sensor_user_config_pkg::ST_ADDR && scl_fall && !bus_stop
      && st_q.bit_cnt == `UCFG_BITS_PER_BYTE && st_q.shift[7:1] != `UCFG_SLAVE_ADDR |=> !sda_oe_out[*2])
    else $error("foreign address acknowledged");
  no_checksum_a: assert property (st_q.state == sensor_user_config_pkg::ST_RACK && scl_rise && !bus_start
      && !bus_stop |=> st_q.state == sensor_user_config_pkg::ST_IDLE && !sda_oe_out)
    else $error("byte driven after configuration byte");
  cmd_ack_a: assert property (st_q.state == sensor_user_config_pkg::ST_CMD && scl_fall && !bus_start
      && !bus_stop && st_q.bit_cnt == `UCFG_BITS_PER_BYTE |=> sda_oe_out)
    else $error("command byte not acknowledged");
  reset_value_a: assert property ($fell(sys_rst_in) |-> cfg_read == `UCFG_RESET_VALUE)
    else $error("reset value wrong");

  write_seen_c: cover property (wr_commit);
  read_seen_c: cover property (rd_load && st_q.cmd == `UCFG_CMD_READ);
  heater_on_c: cover property ($rose(heater_enable_bit_out));
  conv_seen_c: cover property (conv_start_in && resolution_select_out == 2'h3);
endmodule
